// *** ptvl_params.svh ***
// constants for the trip voting block: register map, field positions, votes
// assumes it is included by bare name from the package and the top module
`ifndef PTVL_PARAMS_SVH
`define PTVL_PARAMS_SVH

// register byte addresses
`define PTVL_ADDR_CTRL 12'h000
`define PTVL_ADDR_CMD 12'h004
`define PTVL_ADDR_STATUS 12'h008
`define PTVL_ADDR_CAUSE 12'h00C

// control register fields (level switches)
`define PTVL_CTRL_IR_CHBYP 1:0
`define PTVL_CTRL_SR_CHBYP 3:2
`define PTVL_CTRL_SR_REINST 5:4
`define PTVL_CTRL_RESET 32'h0000_0000

// command register bits (write one, self clearing)
`define PTVL_CMD_PRLOW_BYP 0
`define PTVL_CMD_IR_BLOCK 1
`define PTVL_CMD_SR_BYP 2
`define PTVL_CMD_UNBYPASS 3
`define PTVL_CMD_TRIP_RESET 4

// coincidence votes
`define PTVL_PR_TRIP_VOTE 3'h2
`define PTVL_P10_VOTE 3'h2
`define PTVL_LOOP_VOTE 3'h2

`endif

// *** ptvl_pkg.sv ***
// types shared by the trip voting block and its bench
// assumes ptvl_params.svh is on the include path
`include "ptvl_params.svh"

package ptvl_pkg;

   // bistable levels from the analog channels, high means tripped or above
   typedef struct packed {
      logic [3:0] prHigh;
      logic [3:0] prLow;
      logic [3:0] prRate;
      logic [3:0] prP10;
      logic [1:0] irTrip;
      logic [1:0] irP6;
      logic [1:0] srTrip;
      logic [2:0] otDelta;
      logic [2:0] opDelta;
      logic [2:0] pzrLowPress;
      logic [2:0] pzrHighPress;
      logic [2:0] pzrHighLevel;
      logic lowPowerPermit;
   } ptvl_chan_t;

   // plant-facing outputs, one bit per train or per channel
   typedef struct packed {
      logic [1:0] tripBreaker;
      logic [1:0] turbineTrip;
      logic [1:0] irChanAnn;
      logic [1:0] srChanAnn;
   } ptvl_out_t;

   // sticky record of which functions asked for a trip
   typedef struct packed {
      logic prHigh;
      logic prLow;
      logic prRate;
      logic irHigh;
      logic srHigh;
      logic otDelta;
      logic opDelta;
      logic pzrLow;
      logic pzrHigh;
      logic pzrLevel;
   } ptvl_cause_t;

endpackage

// *** ptvl_top.sv ***
// coincidence voting, permissives and bypasses for the overpower,
// thermal overpower and pressurizer trips of a two-train protection set.
// assumes bistable inputs are synchronous to mclk and APB is the host path.
// Notes on behaviour
// RULE_01 - two of four power range high trips
// RULE_02 - high setting always active, never bypassed
// RULE_03 - low setting bypass only with P10 present
// RULE_04 - losing P10 cancels low setting bypass
// RULE_05 - either intermediate channel trips the reactor
// RULE_06 - intermediate block needs P10, dropped without
// RULE_07 - intermediate channel bypass, annunciated
// RULE_08 - either source range channel trips
// RULE_09 - source bypass needs P6, dropped without
// RULE_10 - P10 automatically bypasses source range
// RULE_11 - each reinstate switch serves one train
// RULE_12 - source channel bypass, annunciated
// RULE_13 - two of four flux rate, unbypassable
// RULE_14 - overtemperature comparators voted per loop
// RULE_15 - overpower comparators voted per loop
// RULE_16 - low pressure blocked below P7
// RULE_17 - high pressure never blocked
// RULE_18 - high level blocked below P7
// RULE_19 - reactor trip also trips the turbine
// RULE_20 - trips latch, reset only once cleared
// RULE_21 - each train ORs its functions independently
`timescale 1ns/1ps
`default_nettype none
`include "ptvl_params.svh"

module ptvl_top
   import ptvl_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // bistable and permissive levels
   input wire ptvl_chan_t chanIn,
   // breakers, turbine and annunciation
   output var ptvl_out_t plantOut
);

   logic [31:0] ctrl;
   logic [1:0] irChanByp;
   logic [1:0] srChanByp;
   logic [1:0] srReinstate;
   logic wrEn;
   logic cmdWr;
   logic mapped;
   logic prLowReq;
   logic irBlockReq;
   logic srBypReq;
   logic unbypassReq;
   logic tripResetReq;
   logic p10;
   logic p6;
   logic prLowByp;
   logic irBlock;
   logic srManByp;
   logic prHighD;
   logic prLowD;
   logic rateD;
   logic irD;
   logic srRaw;
   logic otD;
   logic opD;
   logic pzrLowD;
   logic pzrHighD;
   logic pzrLevelD;
   logic commonD;
   logic [1:0] srD;
   logic [1:0] demand;
   logic [1:0] tripReg;
   ptvl_cause_t causeNow;
   ptvl_cause_t cause;

   // number of asserted bits among up to four
   function automatic logic [2:0] ptvl_count(input logic [3:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 4; i++)
      begin
         n = n + {2'h0, v[i]};
      end
      return n;
   endfunction

   // bus decode; zero wait states keep every answer one access cycle long
   assign pready = 1'b1;
   assign wrEn = psel & penable & pwrite;
   assign mapped = (paddr == `PTVL_ADDR_CTRL) || (paddr == `PTVL_ADDR_CMD) ||
                   (paddr == `PTVL_ADDR_STATUS) || (paddr == `PTVL_ADDR_CAUSE);
   assign pslverr = psel & penable & ~mapped;
   assign cmdWr = wrEn & (paddr == `PTVL_ADDR_CMD);
   assign prLowReq = cmdWr & pwdata[`PTVL_CMD_PRLOW_BYP];
   assign irBlockReq = cmdWr & pwdata[`PTVL_CMD_IR_BLOCK];
   assign srBypReq = cmdWr & pwdata[`PTVL_CMD_SR_BYP];
   assign unbypassReq = cmdWr & pwdata[`PTVL_CMD_UNBYPASS];
   assign tripResetReq = cmdWr & pwdata[`PTVL_CMD_TRIP_RESET];

   assign irChanByp = ctrl[`PTVL_CTRL_IR_CHBYP];
   assign srChanByp = ctrl[`PTVL_CTRL_SR_CHBYP];
   assign srReinstate = ctrl[`PTVL_CTRL_SR_REINST];

   // control register of operator switch levels
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ctrl <= `PTVL_CTRL_RESET;
      end
      else if (wrEn && (paddr == `PTVL_ADDR_CTRL))
      begin
         ctrl <= {26'h000_0000, pwdata[5:0]};
      end
   end

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (psel && !penable)
      begin
         unique case (paddr)
            `PTVL_ADDR_CTRL:
            begin
               prdata <= ctrl;
            end
            `PTVL_ADDR_STATUS:
            begin
               prdata <= {18'h0_0000, chanIn.lowPowerPermit, p6, p10, srManByp, irBlock, prLowByp,
                          srD, plantOut.srChanAnn, plantOut.irChanAnn, tripReg};
            end
            `PTVL_ADDR_CAUSE:
            begin
               prdata <= {22'h00_0000, cause};
            end
            default:
            begin
               prdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // permissives
   assign p10 = ptvl_count(chanIn.prP10) >= `PTVL_P10_VOTE;
   assign p6 = |chanIn.irP6;

   // low setting bypass; loss of P10 outranks any request
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         prLowByp <= 1'b0;
      end
      else if (!p10)
      begin
         prLowByp <= 1'b0; // [RULE_04]
      end
      else if (prLowReq)
      begin
         prLowByp <= 1'b1; // [RULE_03]
      end
      else if (unbypassReq)
      begin
         prLowByp <= 1'b0;
      end
   end

   // intermediate range block
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         irBlock <= 1'b0;
      end
      else if (!p10)
      begin
         irBlock <= 1'b0; // [RULE_06]
      end
      else if (irBlockReq)
      begin
         irBlock <= 1'b1; // [RULE_06]
      end
      else if (unbypassReq)
      begin
         irBlock <= 1'b0;
      end
   end

   // source range manual bypass
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         srManByp <= 1'b0;
      end
      else if (!p6)
      begin
         srManByp <= 1'b0; // [RULE_09]
      end
      else if (srBypReq)
      begin
         srManByp <= 1'b1; // [RULE_09]
      end
      else if (unbypassReq)
      begin
         srManByp <= 1'b0;
      end
   end

   // function demands; setpoints are formed upstream, only comparators arrive here
   assign prHighD = ptvl_count(chanIn.prHigh) >= `PTVL_PR_TRIP_VOTE; // [RULE_01] [RULE_02]
   assign prLowD = (ptvl_count(chanIn.prLow) >= `PTVL_PR_TRIP_VOTE) & ~prLowByp; // [RULE_03]
   assign rateD = ptvl_count(chanIn.prRate) >= `PTVL_PR_TRIP_VOTE; // [RULE_13]
   assign irD = |(chanIn.irTrip & ~irChanByp) & ~irBlock; // [RULE_05] [RULE_07]
   assign srRaw = |(chanIn.srTrip & ~srChanByp) & ~srManByp; // [RULE_08] [RULE_12]
   assign otD = ptvl_count({1'b0, chanIn.otDelta}) >= `PTVL_LOOP_VOTE; // [RULE_14]
   assign opD = ptvl_count({1'b0, chanIn.opDelta}) >= `PTVL_LOOP_VOTE; // [RULE_15]
   assign pzrLowD = (ptvl_count({1'b0, chanIn.pzrLowPress}) >= `PTVL_LOOP_VOTE) &
                    chanIn.lowPowerPermit; // [RULE_16]
   assign pzrHighD = ptvl_count({1'b0, chanIn.pzrHighPress}) >= `PTVL_LOOP_VOTE; // [RULE_17]
   assign pzrLevelD = (ptvl_count({1'b0, chanIn.pzrHighLevel}) >= `PTVL_LOOP_VOTE) &
                      chanIn.lowPowerPermit; // [RULE_18]

   assign commonD = prHighD | prLowD | rateD | irD | otD | opD | pzrLowD | pzrHighD | pzrLevelD;

   assign causeNow = '{prHigh: prHighD, prLow: prLowD, prRate: rateD, irHigh: irD,
                       srHigh: |srD, otDelta: otD, opDelta: opD, pzrLow: pzrLowD,
                       pzrHigh: pzrHighD, pzrLevel: pzrLevelD};

   // sticky causes; a fresh demand wins over the reset command
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         cause <= '0;
      end
      else if (tripResetReq)
      begin
         cause <= causeNow;
      end
      else
      begin
         cause <= cause | causeNow;
      end
   end

   // each train ORs the shared votes with its own source range demand and latches on its own so one failed train cannot hold the other
   for (genvar t = 0; t < 2; t++)
   begin : g_train
      // P10 bypasses source range unless this train's reinstate switch is on
      assign srD[t] = srRaw & ~(p10 & ~srReinstate[t]); // [RULE_10] [RULE_11]
      assign demand[t] = commonD | srD[t]; // [RULE_21]

      always_ff @(posedge mclk)
      begin
         if (!rst_b)
         begin
            tripReg[t] <= 1'b0;
         end
         else if (demand[t])
         begin
            tripReg[t] <= 1'b1; // [RULE_20]
         end
         else if (tripResetReq)
         begin
            tripReg[t] <= 1'b0; // [RULE_20]
         end
      end
   end

   // plant outputs from flops; turbine follows the breaker demand
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         plantOut <= '0;
      end
      else
      begin
         plantOut.tripBreaker <= tripReg; // [RULE_21]
         plantOut.turbineTrip <= tripReg; // [RULE_19]
         plantOut.irChanAnn <= irChanByp; // [RULE_07]
         plantOut.srChanAnn <= srChanByp; // [RULE_12]
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   property p_pr_high;
      prHighD |=> (tripReg == 2'h3) ##1 (plantOut.tripBreaker == 2'h3);
   endproperty
   a_pr_high: assert property (p_pr_high) else $error("power range high vote did not trip"); // [RULE_01]

   property p_high_unbyp;
      (prLowByp && prHighD) |=> tripReg[0] && tripReg[1];
   endproperty
   a_high_unbyp: assert property (p_high_unbyp) else $error("high setting was bypassed"); // [RULE_02]

   property p_low_byp_set;
      $rose(prLowByp) |-> $past(p10) && $past(prLowReq);
   endproperty
   a_low_byp_set: assert property (p_low_byp_set) else $error("low bypass set without P10"); // [RULE_03]

   property p_low_byp_cancel;
      !p10 |=> !prLowByp && !irBlock;
   endproperty
   a_low_byp_cancel: assert property (p_low_byp_cancel) else $error("bypass kept without P10"); // [RULE_04]

   property p_ir_trip;
      (chanIn.irTrip[0] && !irChanByp[0] && !irBlock) |=> tripReg == 2'h3;
   endproperty
   a_ir_trip: assert property (p_ir_trip) else $error("intermediate channel did not trip"); // [RULE_05]

   property p_ir_block_set;
      $rose(irBlock) |-> $past(p10);
   endproperty
   a_ir_block_set: assert property (p_ir_block_set) else $error("intermediate block without P10"); // [RULE_06]

   property p_ir_ann;
      (irChanByp != 2'h0) |=> (plantOut.irChanAnn != 2'h0);
   endproperty
   a_ir_ann: assert property (p_ir_ann) else $error("channel bypass not annunciated"); // [RULE_07]

   property p_sr_p6;
      !p6 |=> !srManByp;
   endproperty
   a_sr_p6: assert property (p_sr_p6) else $error("source bypass kept without P6"); // [RULE_09]

   property p_sr_train;
      (srRaw && p10 && srReinstate == 2'h1) |-> srD[0] && !srD[1];
   endproperty
   a_sr_train: assert property (p_sr_train) else $error("reinstate switch reached wrong train"); // [RULE_11]

   property p_sr_auto;
      (p10 && srReinstate == 2'h0) |-> srD == 2'h0;
   endproperty
   a_sr_auto: assert property (p_sr_auto) else $error("source range not bypassed above P10"); // [RULE_10]

   property p_pzr_high;
      pzrHighD |=> tripReg == 2'h3;
   endproperty
   a_pzr_high: assert property (p_pzr_high) else $error("high pressure trip was blocked"); // [RULE_17]

   property p_rate;
      rateD |=> tripReg == 2'h3;
   endproperty
   a_rate: assert property (p_rate) else $error("flux rate vote did not trip"); // [RULE_13]

   property p_p7_block;
      !chanIn.lowPowerPermit |-> !pzrLowD && !pzrLevelD;
   endproperty
   a_p7_block: assert property (p_p7_block) else $error("pressurizer trip not blocked below P7"); // [RULE_16]

   property p_turbine;
      plantOut.tripBreaker[1] |-> plantOut.turbineTrip[1];
   endproperty
   a_turbine: assert property (p_turbine) else $error("reactor trip without turbine trip"); // [RULE_19]

   property p_latch;
      (tripReg[0] && (demand[0] || !tripResetReq)) |=> tripReg[0];
   endproperty
   a_latch: assert property (p_latch) else $error("trip released while demand stood"); // [RULE_20]

endmodule
`default_nettype wire

// *** ptvl_field_model.sv ***
// bistable channels and field switches feeding the voting block
// assumes the bench sets the wanted levels just after a rising edge
`timescale 1ns/1ps
`default_nettype none

module ptvl_field_model
   import ptvl_pkg::*;
(
   // clock
   input wire logic mclk,
   // wanted levels from the bench
   input wire ptvl_chan_t levelsReq,
   // bistable outputs to the block
   output var ptvl_chan_t chanIn
);
   // bistables settle one edge late, like a real comparator rack
   always_ff @(posedge mclk)
   begin
      chanIn <= levelsReq;
   end
endmodule

`default_nettype wire

// *** protection_trip_voting_logic_tb.sv ***
// random trip voting bench with a behavioural model of every result except the srD bits of the status register
// assumes ptvl_top, ptvl_field_model and ptvl_pkg are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ptvl_params.svh"

module protection_trip_voting_logic_tb
   import ptvl_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   ptvl_chan_t chanIn;
   ptvl_chan_t levelsReq = '0;
   ptvl_out_t plantOut;
   logic [31:0] rdat;
   logic rerr;
   logic [5:0] ctrl = '0;
   logic mLowByp = 1'b0;
   logic mIrBlk = 1'b0;
   logic mSrByp = 1'b0;
   int miscompares = 0;
   int cmp_count = 0;

   always #12.5 mclk = ~mclk;

   ptvl_top DUT (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chanIn(chanIn), .plantOut(plantOut));
   ptvl_field_model FIELD (.mclk(mclk), .levelsReq(levelsReq), .chanIn(chanIn));

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask

   // waits for pready, never assumes the answer comes at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge mclk);
         n++;
      end
      if (n == 50)
         miscompares++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_edges(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // reinstate switch only lifts the P10 auto bypass of its own train
   function automatic logic [1:0] mdl_sr(input ptvl_chan_t c);
      logic p10;
      logic [1:0] r;
      p10 = $countones(c.prP10) >= 2;
      for (int t = 0; t < 2; t++)
         r[t] = (|(c.srTrip & ~ctrl[3:2])) && !mSrByp && !(p10 && !ctrl[4+t]);
      return r;
   endfunction

   // one bit per function, source range from either train
   function automatic logic [9:0] mdl_cause(input ptvl_chan_t c, input logic [1:0] sr);
      logic [9:0] k;
      k[9] = $countones(c.prHigh) >= 2;
      k[8] = $countones(c.prLow) >= 2 && !mLowByp;
      k[7] = $countones(c.prRate) >= 2;
      k[6] = (|(c.irTrip & ~ctrl[1:0])) && !mIrBlk;
      k[5] = |sr;
      k[4] = $countones(c.otDelta) >= 2;
      k[3] = $countones(c.opDelta) >= 2;
      k[2] = c.lowPowerPermit && $countones(c.pzrLowPress) >= 2;
      k[1] = $countones(c.pzrHighPress) >= 2;
      k[0] = c.lowPowerPermit && $countones(c.pzrHighLevel) >= 2;
      return k;
   endfunction

   // permissive loss cancels manual bypasses
   task automatic set_levels(input ptvl_chan_t v);
      @(posedge mclk);
      levelsReq <= v;
      if ($countones(v.prP10) < 2)
      begin
         mLowByp = 1'b0;
         mIrBlk = 1'b0;
      end
      if (v.irP6 == 2'b00)
         mSrByp = 1'b0;
   endtask

   function automatic logic [31:0] mdl_status(input ptvl_chan_t c, input logic [1:0] trip);
      return {18'h0, c.lowPowerPermit, |c.irP6, $countones(c.prP10) >= 2, mSrByp, mIrBlk, mLowByp,
         2'b00, ctrl[3:2], ctrl[1:0], trip};
   endfunction

   initial
   begin
      ptvl_chan_t lv;
      ptvl_chan_t nv;
      logic [63:0] rnd;
      logic [2:0] cmd;
      logic [1:0] dem;
      logic [1:0] sr;
      logic [9:0] cse;
      rnd[31:0] = $urandom(61);
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      wait_edges(1);
      chk_out(plantOut, 8'h00);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk_reg({31'h0, rerr}, 32'h0000_0001);
      apb(1'b1, `PTVL_ADDR_STATUS, 32'hFFFF_FFFF);
      for (int i = 0; i < 150; i++)
      begin
         lv = '0;
         lv.prP10 = 4'($urandom);
         lv.irP6 = 2'($urandom);
         set_levels(lv);
         ctrl = 6'($urandom);
         apb(1'b1, `PTVL_ADDR_CTRL, {26'h0, ctrl});
         apb(1'b0, `PTVL_ADDR_CTRL, 32'h0000_0000);
         chk_reg(rdat, {26'h000_0000, ctrl});
         cmd = 3'($urandom);
         apb(1'b1, `PTVL_ADDR_CMD, {29'h0, cmd});
         mLowByp = cmd[0] && $countones(lv.prP10) >= 2;
         mIrBlk = cmd[1] && $countones(lv.prP10) >= 2;
         mSrByp = cmd[2] && lv.irP6 != 2'b00;
         if ($urandom % 4 == 0)
         begin
            apb(1'b1, `PTVL_ADDR_CMD, 32'h0000_0008);
            {mLowByp, mIrBlk, mSrByp} = 3'b000;
         end
         apb(1'b0, `PTVL_ADDR_STATUS, 32'h0000_0000);
         chk_reg(rdat & 32'h0000_3F3F, mdl_status(lv, 2'b00));
         rnd = {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
         nv = rnd[$bits(ptvl_chan_t)-1:0];
         if ($urandom % 2)
            nv.prP10 = lv.prP10;
         if ($urandom % 2)
            nv.irP6 = lv.irP6;
         set_levels(nv);
         sr = mdl_sr(nv);
         cse = mdl_cause(nv, sr);
         dem = {2{|{cse[9:6], cse[4:0]}}} | sr;
         wait_edges(4);
         chk_out(plantOut, {dem, dem, ctrl[1:0], ctrl[3:2]});
         apb(1'b0, `PTVL_ADDR_STATUS, 32'h0000_0000);
         chk_reg(rdat & 32'h0000_3F3F, mdl_status(nv, dem));
         apb(1'b0, `PTVL_ADDR_CAUSE, 32'h0000_0000);
         chk_reg(rdat, {22'h00_0000, cse});
         apb(1'b1, `PTVL_ADDR_CMD, 32'h0000_0010);
         wait_edges(3);
         chk_out(plantOut, {dem, dem, ctrl[1:0], ctrl[3:2]});
         set_levels('0);
         wait_edges(4);
         chk_out(plantOut, {dem, dem, ctrl[1:0], ctrl[3:2]});
         apb(1'b1, `PTVL_ADDR_CMD, 32'h0000_0010);
         wait_edges(3);
         chk_out(plantOut, {4'h0, ctrl[1:0], ctrl[3:2]});
         apb(1'b0, `PTVL_ADDR_CAUSE, 32'h0000_0000);
         chk_reg(rdat, 32'h0000_0000);
      end
      give_verdict();
   end

   // each pass takes under 60 cycles
   initial
   begin
      #(25 * 20000);
      miscompares++;
      give_verdict();
   end
endmodule

`default_nettype wire
